// ==== hdl/ecb_pkg.sv ====
// Purpose : shared constants for the extended configuration byte block
// Assumes : byte indices as seen by switch, extended read and protected-area requests
// Notes   : byte offsets, field bit positions, the byte reset value and message codes live here
package ecb_pkg;

    // ==========================================================
    // extended byte indices
    localparam logic [8:0] ECB_IDX_FENCE_CTRL   = 9'h01F;
    localparam logic [8:0] ECB_IDX_FLUSH_CTRL   = 9'h020;
    localparam logic [8:0] ECB_IDX_BG_CTRL      = 9'h0A3;
    localparam logic [8:0] ECB_IDX_USER_PROT    = 9'h0AB;
    localparam logic [8:0] ECB_IDX_BOOT_PROT    = 9'h0AD;
    localparam logic [8:0] ECB_IDX_BOOT_PROT_ST = 9'h0AE;
    localparam logic [8:0] ECB_IDX_PROT_INFO    = 9'h0D3;
    localparam logic [8:0] ECB_IDX_FLUSH_POLICY = 9'h0F0;
    localparam logic [8:0] ECB_IDX_FENCE_CAP    = 9'h1E6;

    // ==========================================================
    // authenticated configuration area byte addresses
    localparam logic [7:0] ECB_AREA_MODE_SEL    = 8'h01;
    localparam logic [7:0] ECB_AREA_UPD_MASK    = 8'h02;

    // ==========================================================
    // field positions
    localparam int ECB_BIT_FLUSH     = 0;
    localparam int ECB_BIT_FENCE     = 1;
    localparam int ECB_BIT_FENCE_EN  = 0;
    localparam int ECB_BIT_BG_HOST   = 0;
    localparam int ECB_BIT_BG_AUTO   = 1;
    localparam int ECB_BIT_PROT_SUP  = 0;
    localparam int ECB_BIT_PROT_MODE = 1;
    localparam int ECB_BIT_MODE_ON   = 0;
    localparam int ECB_BIT_UPD_ALLOW = 0;

    // ==========================================================
    // fixed read-only values and reset values
    localparam logic [7:0] ECB_FENCE_CAP_VAL    = 8'h01;
    localparam logic [7:0] ECB_FLUSH_POLICY_VAL = 8'h01;
    localparam logic       ECB_PROT_SUP_VAL     = 1'b1;
    localparam logic [7:0] ECB_BYTE_RST         = 8'h00;

    // ==========================================================
    // protected-partition message types
    localparam logic [15:0] ECB_MSG_CFG_WR_REQ  = 16'h0006;
    localparam logic [15:0] ECB_MSG_CFG_RD_REQ  = 16'h0007;
    localparam logic [15:0] ECB_MSG_CFG_WR_RSP  = 16'h0600;
    localparam logic [15:0] ECB_MSG_CFG_RD_RSP  = 16'h0700;

    // cache flush engine states
    typedef enum logic [0:0] {
        ECB_FL_IDLE,
        ECB_FL_BUSY
    } ecb_flush_state_type;

endpackage

// ==== hdl/ecb_config_bytes.sv ====
// Purpose : extended configuration bytes for cache fence, flush, background work
//           and secure write-protection mode with its authenticated area
// Assumes : message authentication is checked outside; rpmb_auth_ok qualifies requests
// Notes   : protection bytes themselves are held outside; this block only gates them
// ==========================================================
// Overview of operation
// - fence capability byte 486 reads 0x01, fence supported.
// - fence holds later requests until all earlier cached writes are committed.
// - writing one to flush bit starts a full cache flush.
// - fence and flush bits read zero after reset; bits 7..2 reserved.
// - byte 31 bit 0 turns the fence mechanism on or off.
// - flush policy byte 240 reads 0x01, first-in first-out flushing.
// - byte 163 bit 1 clear forbids idle background work; set permits it.
// - protect mode info byte 211 bit 0 reads one, secure mode supported.
// - protect mode info bit 1 mirrors the protect mode select bit.
// - in secure mode, protection byte updates need the allow bit set.
// - mask and mode select bytes change only by authenticated configuration write.
// - authenticated configuration read returns the mode select byte.
// - area is 256 bytes: mode select at 1, mask at 2, rest reserved.
// - changing protect mode leaves existing protections untouched.
// - mode select bit 0 clear means legacy protection updates by both commands.
// - mode select resets to 0x0, starting in legacy protection.
// - no command queue commands or registers exist here.
// - blocked updates give switch error or generic error for the protect command.
// - config write/read types 0x0006/0x0007; answers 0x0600 and read response.
module ecb_config_bytes
    import ecb_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // extended byte write (switch) and read
    input  wire logic        ext_wr_en,
    input  wire logic [8:0]  ext_wr_idx,
    input  wire logic [7:0]  ext_wr_data,
    input  wire logic        ext_rd_en,
    input  wire logic [8:0]  ext_rd_idx,
    output logic      [7:0]  ext_rd_data,
    output logic             ext_rd_valid,
    // protection byte and protect-bit command gating
    input  wire logic        prot_csd_req,
    output logic             prot_wr_accept,
    output logic             prot_csd_accept,
    output logic             switch_error,
    output logic             generic_error,
    // authenticated configuration requests
    input  wire logic        rpmb_req_valid,
    input  wire logic        rpmb_auth_ok,
    input  wire logic [15:0] rpmb_req_type,
    input  wire logic [7:0]  rpmb_req_addr,
    input  wire logic [7:0]  rpmb_req_data,
    output logic             rpmb_rsp_valid,
    output logic      [15:0] rpmb_rsp_type,
    output logic      [7:0]  rpmb_rsp_data,
    // cache and media side
    input  wire logic        flush_done,
    output logic             flush_start,
    output logic             flush_busy,
    output logic             hold_requests,
    // background maintenance and secure mode status
    input  wire logic        dev_idle,
    output logic             bg_allowed,
    output logic             host_kickoff_en,
    output logic             secure_mode
);

    // ==========================================================
    // state
    logic [7:0]          fence_ctrl_r;
    logic [7:0]          flush_ctrl_r;
    logic [7:0]          bg_ctrl_r;
    logic [7:0]          mode_sel_r;
    logic [7:0]          upd_mask_r;
    ecb_flush_state_type fl_state_r;
    logic                fence_pend_r;

    logic wr_fence;
    logic wr_flush;
    logic wr_bg;
    logic wr_prot;
    logic prot_open;
    logic cfg_wr;
    logic cfg_rd;

    // protection bytes that the secure mode guards
    function automatic logic is_prot_idx(input logic [8:0] idx);
        is_prot_idx = (idx == ECB_IDX_USER_PROT) || (idx == ECB_IDX_BOOT_PROT)
                   || (idx == ECB_IDX_BOOT_PROT_ST);
    endfunction

    // write strobes per byte
    assign wr_fence = ext_wr_en && (ext_wr_idx == ECB_IDX_FENCE_CTRL);
    assign wr_flush = ext_wr_en && (ext_wr_idx == ECB_IDX_FLUSH_CTRL);
    assign wr_bg    = ext_wr_en && (ext_wr_idx == ECB_IDX_BG_CTRL);
    assign wr_prot  = ext_wr_en && is_prot_idx(ext_wr_idx);

    // legacy mode always open; secure mode open only with the allow bit
    assign secure_mode = mode_sel_r[ECB_BIT_MODE_ON];
    assign prot_open   = !secure_mode || upd_mask_r[ECB_BIT_UPD_ALLOW];

    // authenticated requests; other message types belong to another engine
    assign cfg_wr = rpmb_req_valid && rpmb_auth_ok && (rpmb_req_type == ECB_MSG_CFG_WR_REQ);
    assign cfg_rd = rpmb_req_valid && rpmb_auth_ok && (rpmb_req_type == ECB_MSG_CFG_RD_REQ);

    // ==========================================================
    // host-written control bytes; only defined bits are stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fence_ctrl_r <= ECB_BYTE_RST;
            bg_ctrl_r    <= ECB_BYTE_RST;
        end else begin
            if (wr_fence) begin
                fence_ctrl_r <= {7'h00, ext_wr_data[ECB_BIT_FENCE_EN]};
            end
            if (wr_bg) begin
                bg_ctrl_r <= {6'h00, ext_wr_data[1:0]};
            end
        end
    end

    // idle maintenance only when the host has permitted it
    assign bg_allowed      = bg_ctrl_r[ECB_BIT_BG_AUTO] && dev_idle;
    assign host_kickoff_en = bg_ctrl_r[ECB_BIT_BG_HOST];

    // ==========================================================
    // flush engine: bits stay set until the media reports the commit done,
    // and a write arriving while busy is dropped since the host sees busy
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fl_state_r   <= ECB_FL_IDLE;
            flush_ctrl_r <= ECB_BYTE_RST;
            fence_pend_r <= 1'b0;
            flush_start  <= 1'b0;
        end else begin
            flush_start <= 1'b0;
            case (fl_state_r)
                ECB_FL_IDLE: begin
                    if (wr_flush && (ext_wr_data[ECB_BIT_FLUSH]
                        || (ext_wr_data[ECB_BIT_FENCE] && fence_ctrl_r[ECB_BIT_FENCE_EN]))) begin
                        fl_state_r   <= ECB_FL_BUSY;
                        flush_start  <= 1'b1;
                        flush_ctrl_r <= {6'h00,
                            ext_wr_data[ECB_BIT_FENCE] && fence_ctrl_r[ECB_BIT_FENCE_EN],
                            ext_wr_data[ECB_BIT_FLUSH]};
                        fence_pend_r <= ext_wr_data[ECB_BIT_FENCE]
                                     && fence_ctrl_r[ECB_BIT_FENCE_EN];
                    end
                end
                ECB_FL_BUSY: begin
                    if (flush_done) begin
                        fl_state_r   <= ECB_FL_IDLE;
                        flush_ctrl_r <= ECB_BYTE_RST;
                        fence_pend_r <= 1'b0;
                    end
                end
                default: fl_state_r <= ECB_FL_IDLE;
            endcase
        end
    end

    assign flush_busy    = (fl_state_r == ECB_FL_BUSY);
    // later requests wait behind the fence until earlier data is committed
    assign hold_requests = fence_pend_r;

    // ==========================================================
    // authenticated area: only bit 0 of each byte is kept, the rest of the
    // 256 bytes is reserved and reads zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_sel_r <= ECB_BYTE_RST;
            upd_mask_r <= ECB_BYTE_RST;
        end else if (cfg_wr) begin
            if (rpmb_req_addr == ECB_AREA_MODE_SEL) begin
                mode_sel_r <= {7'h00, rpmb_req_data[ECB_BIT_MODE_ON]};
            end else if (rpmb_req_addr == ECB_AREA_UPD_MASK) begin
                upd_mask_r <= {7'h00, rpmb_req_data[ECB_BIT_UPD_ALLOW]};
            end
        end
    end

    // answers to authenticated requests, one cycle after the request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rpmb_rsp_valid <= 1'b0;
            rpmb_rsp_type  <= 16'h0000;
            rpmb_rsp_data  <= ECB_BYTE_RST;
        end else begin
            rpmb_rsp_valid <= cfg_wr || cfg_rd;
            if (cfg_wr) begin
                rpmb_rsp_type <= ECB_MSG_CFG_WR_RSP;
                rpmb_rsp_data <= ECB_BYTE_RST;
            end else if (cfg_rd) begin
                rpmb_rsp_type <= ECB_MSG_CFG_RD_RSP;
                if (rpmb_req_addr == ECB_AREA_MODE_SEL) begin
                    rpmb_rsp_data <= mode_sel_r;
                end else if (rpmb_req_addr == ECB_AREA_UPD_MASK) begin
                    rpmb_rsp_data <= upd_mask_r;
                end else begin
                    rpmb_rsp_data <= ECB_BYTE_RST;
                end
            end
        end
    end

    // ==========================================================
    // protection update gating, answered one cycle after the command
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prot_wr_accept  <= 1'b0;
            prot_csd_accept <= 1'b0;
            switch_error    <= 1'b0;
            generic_error   <= 1'b0;
        end else begin
            prot_wr_accept  <= wr_prot && prot_open;
            switch_error    <= wr_prot && !prot_open;
            prot_csd_accept <= prot_csd_req && prot_open;
            generic_error   <= prot_csd_req && !prot_open;
        end
    end

    // ==========================================================
    // extended byte read; unknown indices, queue bytes included, read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_rd_data  <= ECB_BYTE_RST;
            ext_rd_valid <= 1'b0;
        end else begin
            ext_rd_valid <= ext_rd_en;
            if (ext_rd_en) begin
                if (ext_rd_idx == ECB_IDX_FENCE_CAP) begin
                    ext_rd_data <= ECB_FENCE_CAP_VAL;
                end else if (ext_rd_idx == ECB_IDX_FLUSH_POLICY) begin
                    ext_rd_data <= ECB_FLUSH_POLICY_VAL;
                end else if (ext_rd_idx == ECB_IDX_PROT_INFO) begin
                    ext_rd_data <= {6'h00, secure_mode, ECB_PROT_SUP_VAL};
                end else if (ext_rd_idx == ECB_IDX_FENCE_CTRL) begin
                    ext_rd_data <= fence_ctrl_r;
                end else if (ext_rd_idx == ECB_IDX_FLUSH_CTRL) begin
                    ext_rd_data <= flush_ctrl_r;
                end else if (ext_rd_idx == ECB_IDX_BG_CTRL) begin
                    ext_rd_data <= bg_ctrl_r;
                end else begin
                    ext_rd_data <= ECB_BYTE_RST;
                end
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_fence_write;
        wr_flush && ext_wr_data[ECB_BIT_FENCE] && fence_ctrl_r[ECB_BIT_FENCE_EN]
            && !flush_busy;
    endsequence

    sequence s_blocked_prot;
        wr_prot && secure_mode && !upd_mask_r[ECB_BIT_UPD_ALLOW];
    endsequence

    chk_cap_read_value: assert property (@(posedge clk) disable iff (!nrst)
        ext_rd_en && ext_rd_idx == ECB_IDX_FENCE_CAP |=> ext_rd_data == 8'h01)
        else $error("fence capability did not read 0x01");

    chk_policy_read_value: assert property (@(posedge clk) disable iff (!nrst)
        ext_rd_en && ext_rd_idx == ECB_IDX_FLUSH_POLICY |=> ext_rd_data == 8'h01)
        else $error("flush policy did not read 0x01");

    chk_info_mirror: assert property (@(posedge clk) disable iff (!nrst)
        ext_rd_en && ext_rd_idx == ECB_IDX_PROT_INFO && !cfg_wr
        |=> ext_rd_data == {6'h00, $past(mode_sel_r[0]), 1'b1})
        else $error("protect info byte does not mirror mode");

    chk_flush_start: assert property (@(posedge clk) disable iff (!nrst)
        wr_flush && ext_wr_data[ECB_BIT_FLUSH] && !flush_busy
        |=> flush_start && flush_busy && flush_ctrl_r[0])
        else $error("flush write did not start a flush");

    chk_fence_holds: assert property (@(posedge clk) disable iff (!nrst)
        s_fence_write |=> hold_requests && flush_busy)
        else $error("fence not raised with its flush");

    // the hold may only drop after the media has reported the commit
    chk_fence_stays: assert property (@(posedge clk) disable iff (!nrst)
        hold_requests && !flush_done |=> hold_requests)
        else $error("fence released before commit");

    chk_fence_release: assert property (@(posedge clk) disable iff (!nrst)
        $fell(hold_requests) |-> $past(flush_done))
        else $error("fence dropped without flush completion");

    chk_bg_gate: assert property (@(posedge clk) disable iff (!nrst)
        wr_bg && !ext_wr_data[ECB_BIT_BG_AUTO] |=> !bg_allowed)
        else $error("background work allowed without permission");

    chk_switch_error: assert property (@(posedge clk) disable iff (!nrst)
        s_blocked_prot |=> switch_error && !prot_wr_accept)
        else $error("blocked protection byte write not refused");

    chk_generic_error: assert property (@(posedge clk) disable iff (!nrst)
        prot_csd_req && !prot_open |=> generic_error && !prot_csd_accept)
        else $error("blocked protect bit change not refused");

    chk_ext_no_mode: assert property (@(posedge clk) disable iff (!nrst)
        ext_wr_en && !cfg_wr |=> $stable(mode_sel_r) && $stable(upd_mask_r))
        else $error("ordinary write changed authenticated area");

    chk_cfg_wr_rsp: assert property (@(posedge clk) disable iff (!nrst)
        cfg_wr |=> rpmb_rsp_valid && rpmb_rsp_type == 16'h0600)
        else $error("config write answer type wrong");

    chk_cfg_rd_mode: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && rpmb_req_addr == ECB_AREA_MODE_SEL
        |=> rpmb_rsp_data == $past(mode_sel_r) && rpmb_rsp_type == 16'h0700)
        else $error("config read did not return mode select");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        ext_rd_en && ext_rd_idx == ECB_IDX_FLUSH_CTRL |=> ext_rd_data[7:2] == 6'h00)
        else $error("reserved flush control bits not zero");

endmodule

// ==== sim/ecb_host_model.sv ====
// Purpose : host controller side model issuing switch, extended read and
//           authenticated configuration requests
// Assumes : requests launch on the falling edge and are taken at the next rising edge
// Notes   : released index, address, data and auth fields are inverted so a stale value never looks valid; the type is kept
module ecb_host_model (
    // clock
    input  wire logic        clk,
    // extended byte access
    output logic             ext_wr_en,
    output logic      [8:0]  ext_wr_idx,
    output logic      [7:0]  ext_wr_data,
    output logic             ext_rd_en,
    output logic      [8:0]  ext_rd_idx,
    input  wire logic [7:0]  ext_rd_data,
    input  wire logic        ext_rd_valid,
    // authenticated configuration requests
    output logic             rpmb_req_valid,
    output logic             rpmb_auth_ok,
    output logic      [15:0] rpmb_req_type,
    output logic      [7:0]  rpmb_req_addr,
    output logic      [7:0]  rpmb_req_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // idle bus at time zero
    initial begin
        {ext_wr_en, ext_rd_en, rpmb_req_valid, rpmb_auth_ok} = 4'h0;
        {ext_wr_idx, ext_rd_idx} = 18'h00000;
        {ext_wr_data, rpmb_req_data, rpmb_req_addr} = 24'h000000;
        rpmb_req_type = 16'h0000;
    end

    // one-cycle switch write; the host alone decides what it writes
    task automatic wr(input logic [8:0] idx, input logic [7:0] dat);
        @(negedge clk);
        ext_wr_en   = 1'b1;
        ext_wr_idx  = idx;
        ext_wr_data = dat;
        @(negedge clk);
        ext_wr_en   = 1'b0;
        ext_wr_idx  = ~idx;
        ext_wr_data = ~dat;
    endtask

    // extended read; answer sampled while it stands, valid flag on top
    task automatic rd(input logic [8:0] idx, output logic [8:0] got);
        @(negedge clk);
        ext_rd_en  = 1'b1;
        ext_rd_idx = idx;
        @(negedge clk);
        ext_rd_en  = 1'b0;
        ext_rd_idx = ~idx;
        got        = {ext_rd_valid, ext_rd_data};
    endtask

    // authenticated request; a failed check is modelled by auth low
    task automatic rpmb(input logic [15:0] typ, input logic auth,
                        input logic [7:0] addr, input logic [7:0] dat);
        @(negedge clk);
        rpmb_req_valid = 1'b1;
        rpmb_auth_ok   = auth;
        rpmb_req_type  = typ;
        rpmb_req_addr  = addr;
        rpmb_req_data  = dat;
        @(negedge clk);
        rpmb_req_valid = 1'b0;
        rpmb_auth_ok   = ~auth;
        rpmb_req_addr  = ~addr;
        rpmb_req_data  = ~dat;
    endtask
endmodule

// ==== sim/ecb_config_bytes_tb.sv ====
// Purpose : self-checking bench for the extended configuration byte block
// Assumes : inputs change on the falling edge; answers are checked while they stand
// Notes   : the media side flush completion and idle level are driven here
module ecb_config_bytes_tb
    import ecb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    logic clk, nrst, ext_wr_en, ext_rd_en, ext_rd_valid, prot_csd_req, prot_wr_accept;
    logic prot_csd_accept, switch_error, generic_error, rpmb_req_valid, rpmb_auth_ok;
    logic rpmb_rsp_valid, flush_done, flush_start, flush_busy, hold_requests, dev_idle;
    logic bg_allowed, host_kickoff_en, secure_mode;
    logic [8:0]  ext_wr_idx, ext_rd_idx;
    logic [7:0]  ext_wr_data, ext_rd_data, rpmb_req_addr, rpmb_req_data, rpmb_rsp_data;
    logic [15:0] rpmb_req_type, rpmb_rsp_type;
    int          errors, comparisons;

    ecb_config_bytes u_ecb_config_bytes (.clk(clk), .nrst(nrst), .ext_wr_en(ext_wr_en),
        .ext_wr_idx(ext_wr_idx), .ext_wr_data(ext_wr_data), .ext_rd_en(ext_rd_en),
        .ext_rd_idx(ext_rd_idx), .ext_rd_data(ext_rd_data), .ext_rd_valid(ext_rd_valid),
        .prot_csd_req(prot_csd_req), .prot_wr_accept(prot_wr_accept),
        .prot_csd_accept(prot_csd_accept), .switch_error(switch_error),
        .generic_error(generic_error), .rpmb_req_valid(rpmb_req_valid),
        .rpmb_auth_ok(rpmb_auth_ok), .rpmb_req_type(rpmb_req_type),
        .rpmb_req_addr(rpmb_req_addr), .rpmb_req_data(rpmb_req_data),
        .rpmb_rsp_valid(rpmb_rsp_valid), .rpmb_rsp_type(rpmb_rsp_type),
        .rpmb_rsp_data(rpmb_rsp_data), .flush_done(flush_done), .flush_start(flush_start),
        .flush_busy(flush_busy), .hold_requests(hold_requests), .dev_idle(dev_idle),
        .bg_allowed(bg_allowed), .host_kickoff_en(host_kickoff_en),
        .secure_mode(secure_mode));

    ecb_host_model u_ecb_host_model (.clk(clk), .ext_wr_en(ext_wr_en),
        .ext_wr_idx(ext_wr_idx), .ext_wr_data(ext_wr_data), .ext_rd_en(ext_rd_en),
        .ext_rd_idx(ext_rd_idx), .ext_rd_data(ext_rd_data), .ext_rd_valid(ext_rd_valid),
        .rpmb_req_valid(rpmb_req_valid), .rpmb_auth_ok(rpmb_auth_ok),
        .rpmb_req_type(rpmb_req_type), .rpmb_req_addr(rpmb_req_addr),
        .rpmb_req_data(rpmb_req_data));

    // ==========================================================
    // clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [8:0] idx, input logic [7:0] exp);
        logic [8:0] got;
        u_ecb_host_model.rd(idx, got);
        check(32'(got), 32'({1'b1, exp}));
    endtask

    // answer packed as valid, type, data so one compare covers all three
    function automatic logic [31:0] rsp();
        return 32'({rpmb_rsp_valid, rpmb_rsp_type, rpmb_rsp_data});
    endfunction

    task automatic pulse_req(ref logic sig);
        @(negedge clk);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
    endtask

    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic test_fixed();
        rdc(ECB_IDX_FENCE_CAP, 8'h01);
        u_ecb_host_model.wr(ECB_IDX_FENCE_CAP, 8'hFF);
        rdc(ECB_IDX_FENCE_CAP, 8'h01);
        rdc(ECB_IDX_FLUSH_POLICY, 8'h01);
        rdc(ECB_IDX_PROT_INFO, 8'h01);
        rdc(ECB_IDX_FLUSH_CTRL, 8'h00);
        rdc(ECB_IDX_FENCE_CTRL, 8'h00);
    endtask

    task automatic test_background();
        u_ecb_host_model.wr(ECB_IDX_BG_CTRL, 8'hFF);
        rdc(ECB_IDX_BG_CTRL, 8'h03);
        dev_idle = 1'b1;
        @(negedge clk) check(32'({bg_allowed, host_kickoff_en}), 32'h3);
        dev_idle = 1'b0;
        @(negedge clk) check(32'(bg_allowed), 32'h0);
        u_ecb_host_model.wr(ECB_IDX_BG_CTRL, 8'h01);
        dev_idle = 1'b1;
        @(negedge clk) check(32'({bg_allowed, host_kickoff_en}), 32'h1);
        u_ecb_host_model.wr(ECB_IDX_BG_CTRL, 8'h00);
        check(32'(host_kickoff_en), 32'h0);
    endtask

    // host sequence: fence before enable ignored, enable, fence with flush, then plain flush
    task automatic test_fence();
        u_ecb_host_model.wr(ECB_IDX_FLUSH_CTRL, 8'h02);
        check(32'({flush_start, flush_busy}), 32'h0);
        u_ecb_host_model.wr(ECB_IDX_FENCE_CTRL, 8'hFF);
        rdc(ECB_IDX_FENCE_CTRL, 8'h01);
        u_ecb_host_model.wr(ECB_IDX_FLUSH_CTRL, 8'hFF);
        check(32'({flush_start, flush_busy, hold_requests}), 32'h7);
        rdc(ECB_IDX_FLUSH_CTRL, 8'h03);
        check(32'({flush_start, flush_busy, hold_requests}), 32'h3);
        u_ecb_host_model.wr(ECB_IDX_FLUSH_CTRL, 8'h00);
        rdc(ECB_IDX_FLUSH_CTRL, 8'h03);
        pulse_req(flush_done);
        check(32'({flush_busy, hold_requests}), 32'h0);
        rdc(ECB_IDX_FLUSH_CTRL, 8'h00);
        u_ecb_host_model.wr(ECB_IDX_FLUSH_CTRL, 8'h01);
        check(32'({flush_start, flush_busy, hold_requests}), 32'h6);
        pulse_req(flush_done);
        check(32'(flush_busy), 32'h0);
    endtask

    task automatic test_protect();
        pulse_req(prot_csd_req);
        check(32'({prot_csd_accept, generic_error}), 32'h2);
        u_ecb_host_model.wr(ECB_IDX_USER_PROT, 8'h05);
        check(32'({prot_wr_accept, switch_error}), 32'h2);
        u_ecb_host_model.wr(9'h001, 8'hFF);
        check(32'(secure_mode), 32'h0);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_WR_REQ, 1'b1, ECB_AREA_MODE_SEL, 8'hFF);
        check(rsp(), 32'h0106_0000);
        check(32'(secure_mode), 32'h1);
        rdc(ECB_IDX_PROT_INFO, 8'h03);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_RD_REQ, 1'b1, ECB_AREA_MODE_SEL, 8'h00);
        check(rsp(), 32'h0107_0001);
        pulse_req(prot_csd_req);
        check(32'({prot_csd_accept, generic_error}), 32'h1);
        u_ecb_host_model.wr(ECB_IDX_BOOT_PROT, 8'h01);
        check(32'({prot_wr_accept, switch_error}), 32'h1);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_WR_REQ, 1'b0, ECB_AREA_UPD_MASK, 8'h01);
        check(32'(rpmb_rsp_valid), 32'h0);
        u_ecb_host_model.rpmb(16'h0003, 1'b1, ECB_AREA_UPD_MASK, 8'h01);
        check(32'(rpmb_rsp_valid), 32'h0);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_RD_REQ, 1'b1, ECB_AREA_UPD_MASK, 8'h00);
        check(rsp(), 32'h0107_0000);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_WR_REQ, 1'b1, 8'h00, 8'hFF);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_RD_REQ, 1'b1, 8'h00, 8'h00);
        check(rsp(), 32'h0107_0000);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_WR_REQ, 1'b1, ECB_AREA_UPD_MASK, 8'hFF);
        u_ecb_host_model.wr(ECB_IDX_BOOT_PROT_ST, 8'h01);
        check(32'({prot_wr_accept, switch_error}), 32'h2);
        pulse_req(prot_csd_req);
        check(32'({prot_csd_accept, generic_error}), 32'h2);
        u_ecb_host_model.rpmb(ECB_MSG_CFG_RD_REQ, 1'b1, ECB_AREA_UPD_MASK, 8'h00);
        check(rsp(), 32'h0107_0001);
    endtask

    // a reset in mid-run must drop back to legacy protection
    task automatic test_reset();
        @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        check(32'(secure_mode), 32'h0);
        rdc(ECB_IDX_PROT_INFO, 8'h01);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {nrst, dev_idle, flush_done, prot_csd_req} = 4'h0;
        errors      = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        test_fixed();
        test_background();
        test_fence();
        test_protect();
        test_reset();
        stop_test();
    end

    // watchdog: the whole run needs well under two thousand cycles
    initial begin
        #50us;
        errors++;
        stop_test();
    end
endmodule
